// *** src/dbg_consts.vh ***
// named constants shared by the debug state control files
`ifndef DBG_CONSTS_VH
`define DBG_CONSTS_VH

// ----------------------------------------------------------------
// register offsets (byte addresses on the register bus)
// ----------------------------------------------------------------
`define ADDR_DCSR      8'h00
`define ADDR_DPC       8'h04
`define ADDR_DSCRATCH0 8'h08
`define ADDR_DSCRATCH1 8'h0c
`define ADDR_TSELECT   8'h10
`define ADDR_TDATA1    8'h14
`define ADDR_TDATA2    8'h18
`define ADDR_TINFO     8'h1c
`define ADDR_DSTATE    8'h20

// ----------------------------------------------------------------
// debug control and status fields
// ----------------------------------------------------------------
`define DCSR_VER_MSB   31
`define DCSR_VER_LSB   28
`define DCSR_VER_VAL   4'h4
`define DCSR_EBREAKM   15
`define DCSR_CAUSE_MSB 8
`define DCSR_CAUSE_LSB 6
`define DCSR_STEP      2
`define DCSR_PRV_MSB   1
`define DCSR_PRV_LSB   0
`define DCSR_PRV_VAL   2'h3
`define EBREAKM_RST    1'h0
`define STEP_RST       1'h0

// entry causes recorded in the cause field
`define CAUSE_NONE     3'h0
`define CAUSE_EBREAK   3'h1
`define CAUSE_TRIGGER  3'h2
`define CAUSE_HALTREQ  3'h3
`define CAUSE_STEP     3'h4

// ----------------------------------------------------------------
// trigger fields
// ----------------------------------------------------------------
`define TDATA1_TYPE_MSB 31
`define TDATA1_TYPE_LSB 28
`define TDATA1_TYPE_VAL 4'h2
`define TDATA1_DMODE    27
`define TDATA1_DMODE_VAL 1'h1
`define TDATA1_M        6
`define TDATA1_EXEC     2
`define TINFO_VAL       32'h0000_0004

// ----------------------------------------------------------------
// misc values
// ----------------------------------------------------------------
`define WORD_ZERO      32'h0000_0000
`define EXC_BREAKPOINT 5'h03

`endif

// *** src/level_sync.v ***
// two-stage synchroniser for a single level from outside the clock domain
`timescale 1ns/1ps
`default_nettype none

module level_sync (
   // clock and reset
   input wire clk,
   input wire rst_n,
   // level in and synchronised level out
   input wire d,
   output wire q
);

   reg meta_ff;
   reg sync_ff;

   // the first stage is read only by the second stage
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         meta_ff <= 1'b0;
         sync_ff <= 1'b0;
      end else begin
         meta_ff <= d;
         sync_ff <= meta_ff;
      end
   end

   assign q = sync_ff;

endmodule
`default_nettype wire

// *** src/word_reg.v ***
// one 32-bit storage word with load enable
`timescale 1ns/1ps
`include "dbg_consts.vh"
`default_nettype none

module word_reg (
   // clock and reset
   input wire clk,
   input wire rst_n,
   // load port
   input wire we,
   input wire [31:0] d,
   // stored value
   output wire [31:0] q
);

   reg [31:0] word_ff;

   // holds its value unless loaded
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         word_ff <= `WORD_ZERO;
      end else if (we) begin
         word_ff <= d;
      end
   end

   assign q = word_ff;

endmodule
`default_nettype wire

// *** src/core_debug_state_control.v ***
// debug state machine, debug csrs and trigger of the core
//
// Function
// - four debug csrs; access outside debug mode is an illegal instruction
// - trigger dmode field always reads one and ignores writes
// - trigger writes outside debug mode are dropped, reads still work
// - unavailable state shows neither running nor halted
// - unavailable from reset until cycles after release and fetch permit high
// - after that, halted in debug mode, running otherwise
// - exactly one of reset-seen, running, halted is high each cycle
// - unavailable lasts as long as reset or low fetch permit lasts
// - halt request before fetch permit gives direct unavailable to halted
// - later halt request may pass through running first
// - halt request while running always reaches halted within cycles
// - ebreak with ebreakm zero traps to mtvec, no debug entry
// - no trap value register; faulting instruction word not kept
// - ebreak with ebreakm one enters debug, updates dpc and dcsr
// - ebreak entry leaves dpc on the ebreak; debugger must advance it
// - ebreakm resets to zero, settable only from debug mode
// - ebreak inside debug mode jumps to entry vector, csrs unchanged
// - interrupt during step retires handler's first instruction then halts
// - any entry saves pc, records cause, fetches at entry vector
// - exception in debug mode fetches at fault vector
// - halt request is synchronous; decoded instruction is killed
// - reset-seen high during reset, cleared after fetch permit seen
`timescale 1ns/1ps
`include "dbg_consts.vh"
`default_nettype none

module core_debug_state_control (
   // clock and reset
   input wire pclk,
   input wire presetn,
   // register bus
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [7:0] paddr,
   input wire [31:0] pwdata,
   output reg [31:0] prdata,
   output wire pready,
   output wire pslverr,
   // debug module side
   input wire fetch_enable,
   input wire debug_req,
   input wire [31:0] debugger_entry_vector,
   input wire [31:0] debugger_fault_vector,
   output reg havereset,
   output reg running,
   output reg halted,
   output wire debug_mode,
   // pipeline events
   input wire decode_valid,
   input wire [31:0] decode_pc,
   input wire [31:0] next_pc,
   input wire ebreak_exec,
   input wire exc_raise,
   input wire retire,
   input wire irq_taken,
   input wire dret_exec,
   // pipeline control
   output wire kill_decode,
   output wire illegal_insn,
   output reg redirect_valid,
   output reg [31:0] redirect_addr,
   output reg trap_valid,
   output reg [31:0] trap_mepc,
   output wire [4:0] trap_mcause
);

   // ----------------------------------------------------------------
   // states and storage
   // ----------------------------------------------------------------
   localparam [1:0] ST_RESET = 2'h0;
   localparam [1:0] ST_RUN = 2'h1;
   localparam [1:0] ST_HALT = 2'h2;

   reg [1:0] state_ff, nxt_state;
   reg req_seen_ff, nxt_req_seen;
   reg step_pend_ff, nxt_step_pend;
   reg ebreakm_ff, nxt_ebreakm;
   reg step_ff, nxt_step;
   reg [2:0] cause_ff, nxt_cause;
   reg trig_exec_ff, nxt_trig_exec;
   reg trig_m_ff, nxt_trig_m;
   reg nxt_redirect_valid;
   reg [31:0] nxt_redirect_addr;
   reg nxt_trap_valid;
   reg [31:0] nxt_trap_mepc;
   reg enter;
   reg [2:0] ent_cause;
   reg [31:0] ent_pc;
   reg kill;
   reg [31:0] rd_mux;

   wire fetch_en_s;
   wire [31:0] dpc_q, scr0_q, scr1_q, tdata2_q;
   wire [31:0] dcsr_val, tdata1_val, dstate_val;

   // the permit comes from a pin, so it is synchronised before use
   level_sync u_fetch_sync (
      .clk(pclk),
      .rst_n(presetn),
      .d(fetch_enable),
      .q(fetch_en_s)
   );

   // ----------------------------------------------------------------
   // register bus decode
   // ----------------------------------------------------------------
   wire in_dm = (state_ff == ST_HALT);
   wire apb_acc = psel & penable;
   wire apb_wr = apb_acc & pwrite;
   wire sel_dcsr = (paddr == `ADDR_DCSR);
   wire sel_dpc = (paddr == `ADDR_DPC);
   wire sel_scr0 = (paddr == `ADDR_DSCRATCH0);
   wire sel_scr1 = (paddr == `ADDR_DSCRATCH1);
   wire sel_tsel = (paddr == `ADDR_TSELECT);
   wire sel_td1 = (paddr == `ADDR_TDATA1);
   wire sel_td2 = (paddr == `ADDR_TDATA2);
   wire sel_tinfo = (paddr == `ADDR_TINFO);
   wire sel_state = (paddr == `ADDR_DSTATE);
   wire dbg_csr = sel_dcsr | sel_dpc | sel_scr0 | sel_scr1;
   wire trig_csr = sel_tsel | sel_td1 | sel_td2 | sel_tinfo;
   wire mapped = dbg_csr | trig_csr | sel_state;
   // writes to debug and trigger words only land in debug mode
   wire csr_wr_ok = apb_wr & in_dm;

   // zero wait states; errors flag unmapped or illegal accesses
   assign pready = 1'b1;
   assign illegal_insn = apb_acc & dbg_csr & ~in_dm;
   assign pslverr = apb_acc & (~mapped | (dbg_csr & ~in_dm));

   // ----------------------------------------------------------------
   // visible register values
   // ----------------------------------------------------------------
   assign dcsr_val = {`DCSR_VER_VAL, 12'h000, ebreakm_ff, 6'h00, cause_ff,
                      3'h0, step_ff, `DCSR_PRV_VAL};
   // dmode is a constant one, so no write can clear it
   assign tdata1_val = {`TDATA1_TYPE_VAL, `TDATA1_DMODE_VAL, 20'h00000,
                        trig_m_ff, 3'h0, trig_exec_ff, 2'h0};
   assign dstate_val = {29'h0000_0000, halted, running, havereset};

   // read mux; trigger words read back in any mode
   always @* begin
      rd_mux = `WORD_ZERO;
      case (paddr)
         `ADDR_DCSR: rd_mux = in_dm ? dcsr_val : `WORD_ZERO;
         `ADDR_DPC: rd_mux = in_dm ? dpc_q : `WORD_ZERO;
         `ADDR_DSCRATCH0: rd_mux = in_dm ? scr0_q : `WORD_ZERO;
         `ADDR_DSCRATCH1: rd_mux = in_dm ? scr1_q : `WORD_ZERO;
         `ADDR_TSELECT: rd_mux = `WORD_ZERO;
         `ADDR_TDATA1: rd_mux = tdata1_val;
         `ADDR_TDATA2: rd_mux = tdata2_q;
         `ADDR_TINFO: rd_mux = `TINFO_VAL;
         `ADDR_DSTATE: rd_mux = dstate_val;
         default: rd_mux = `WORD_ZERO;
      endcase
   end

   // read data is captured in the setup cycle so it comes from a flop
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= `WORD_ZERO;
      end else if (psel & ~penable & ~pwrite) begin
         prdata <= rd_mux;
      end
   end

   // ----------------------------------------------------------------
   // debug state machine
   // ----------------------------------------------------------------
   // an execute trigger matches the pc of the instruction in decode
   wire trig_hit = trig_exec_ff & trig_m_ff & decode_valid & (decode_pc == tdata2_q);

   always @* begin
      nxt_state = state_ff;
      nxt_req_seen = req_seen_ff;
      nxt_step_pend = step_pend_ff;
      nxt_redirect_valid = 1'b0;
      nxt_redirect_addr = redirect_addr;
      nxt_trap_valid = 1'b0;
      nxt_trap_mepc = trap_mepc;
      enter = 1'b0;
      ent_cause = `CAUSE_NONE;
      ent_pc = decode_pc;
      kill = 1'b0;
      case (state_ff)
         ST_RESET: begin
            // wait here as long as the permit stays low; no timeout
            nxt_req_seen = req_seen_ff | debug_req;
            if (fetch_en_s) begin
               if (req_seen_ff | debug_req) begin
                  enter = 1'b1;
                  ent_cause = `CAUSE_HALTREQ;
                  ent_pc = next_pc;
               end else begin
                  nxt_state = ST_RUN;
               end
            end
         end
         ST_RUN: begin
            if (debug_req) begin
               // the instruction in decode is killed and becomes dpc
               enter = 1'b1;
               ent_cause = `CAUSE_HALTREQ;
               kill = 1'b1;
            end else if (trig_hit) begin
               enter = 1'b1;
               ent_cause = `CAUSE_TRIGGER;
               kill = 1'b1;
            end else if (ebreak_exec) begin
               if (ebreakm_ff) begin
                  // dpc stays on the ebreak itself
                  enter = 1'b1;
                  ent_cause = `CAUSE_EBREAK;
               end else begin
                  // ordinary breakpoint trap; no trap value is kept
                  nxt_trap_valid = 1'b1;
                  nxt_trap_mepc = decode_pc;
               end
            end else if (step_pend_ff & retire & ~irq_taken) begin
               // a taken interrupt wins over a retire, so the first
               // handler instruction is the one that retires here
               enter = 1'b1;
               ent_cause = `CAUSE_STEP;
               ent_pc = next_pc;
            end
         end
         ST_HALT: begin
            if (ebreak_exec) begin
               // restart debug code, no csr is touched
               nxt_redirect_valid = 1'b1;
               nxt_redirect_addr = debugger_entry_vector;
            end else if (exc_raise) begin
               nxt_redirect_valid = 1'b1;
               nxt_redirect_addr = debugger_fault_vector;
            end else if (dret_exec) begin
               nxt_state = ST_RUN;
               nxt_redirect_valid = 1'b1;
               nxt_redirect_addr = dpc_q;
               nxt_step_pend = step_ff;
            end
         end
         default: begin
            nxt_state = ST_RESET;
         end
      endcase
      // common entry actions for every cause
      if (enter) begin
         nxt_state = ST_HALT;
         nxt_redirect_valid = 1'b1;
         nxt_redirect_addr = debugger_entry_vector;
         nxt_step_pend = 1'b0;
         nxt_req_seen = 1'b0;
      end
   end

   assign kill_decode = kill;
   assign debug_mode = in_dm;
   assign trap_mcause = `EXC_BREAKPOINT;

   // ----------------------------------------------------------------
   // csr field updates
   // ----------------------------------------------------------------
   // ebreakm and step can only be written from debug mode
   always @* begin
      nxt_ebreakm = ebreakm_ff;
      nxt_step = step_ff;
      nxt_cause = cause_ff;
      nxt_trig_exec = trig_exec_ff;
      nxt_trig_m = trig_m_ff;
      if (csr_wr_ok & sel_dcsr) begin
         nxt_ebreakm = pwdata[`DCSR_EBREAKM];
         nxt_step = pwdata[`DCSR_STEP];
      end
      if (csr_wr_ok & sel_td1) begin
         nxt_trig_exec = pwdata[`TDATA1_EXEC];
         nxt_trig_m = pwdata[`TDATA1_M];
      end
      if (enter) begin
         nxt_cause = ent_cause;
      end
   end

   // dpc takes the entry pc, or a debugger write while halted
   wire dpc_we = enter | (csr_wr_ok & sel_dpc);
   wire [31:0] dpc_d = enter ? ent_pc : pwdata;

   word_reg u_dpc (
      .clk(pclk),
      .rst_n(presetn),
      .we(dpc_we),
      .d(dpc_d),
      .q(dpc_q)
   );

   word_reg u_scratch0 (
      .clk(pclk),
      .rst_n(presetn),
      .we(csr_wr_ok & sel_scr0),
      .d(pwdata),
      .q(scr0_q)
   );

   word_reg u_scratch1 (
      .clk(pclk),
      .rst_n(presetn),
      .we(csr_wr_ok & sel_scr1),
      .d(pwdata),
      .q(scr1_q)
   );

   word_reg u_tdata2 (
      .clk(pclk),
      .rst_n(presetn),
      .we(csr_wr_ok & sel_td2),
      .d(pwdata),
      .q(tdata2_q)
   );

   // ----------------------------------------------------------------
   // state registers
   // ----------------------------------------------------------------
   // flags are decoded from the next state so each is a plain flop
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_ff <= ST_RESET;
         havereset <= 1'b1;
         running <= 1'b0;
         halted <= 1'b0;
         req_seen_ff <= 1'b0;
         step_pend_ff <= 1'b0;
         ebreakm_ff <= `EBREAKM_RST;
         step_ff <= `STEP_RST;
         cause_ff <= `CAUSE_NONE;
         trig_exec_ff <= 1'b0;
         trig_m_ff <= 1'b0;
         redirect_valid <= 1'b0;
         redirect_addr <= `WORD_ZERO;
         trap_valid <= 1'b0;
         trap_mepc <= `WORD_ZERO;
      end else begin
         state_ff <= nxt_state;
         havereset <= (nxt_state == ST_RESET);
         running <= (nxt_state == ST_RUN);
         halted <= (nxt_state == ST_HALT);
         req_seen_ff <= nxt_req_seen;
         step_pend_ff <= nxt_step_pend;
         ebreakm_ff <= nxt_ebreakm;
         step_ff <= nxt_step;
         cause_ff <= nxt_cause;
         trig_exec_ff <= nxt_trig_exec;
         trig_m_ff <= nxt_trig_m;
         redirect_valid <= nxt_redirect_valid;
         redirect_addr <= nxt_redirect_addr;
         trap_valid <= nxt_trap_valid;
         trap_mepc <= nxt_trap_mepc;
      end
   end

endmodule
`default_nettype wire

// *** test/dbg_state_props.sv ***
// concurrent checks on the debug state control ports
`timescale 1ns/1ps
`default_nettype none

module dbg_state_props (
   // clock and reset
   input wire pclk,
   input wire presetn,
   // register bus
   input wire psel,
   input wire penable,
   input wire [7:0] paddr,
   input wire pslverr,
   // debug module side
   input wire fetch_enable,
   input wire debug_req,
   input wire [31:0] debugger_entry_vector,
   input wire [31:0] debugger_fault_vector,
   input wire havereset,
   input wire running,
   input wire halted,
   // pipeline
   input wire [31:0] decode_pc,
   input wire ebreak_exec,
   input wire exc_raise,
   input wire kill_decode,
   input wire illegal_insn,
   input wire redirect_valid,
   input wire [31:0] redirect_addr,
   input wire trap_valid,
   input wire [31:0] trap_mepc
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   // remembers a halt request seen while the core was still unavailable
   reg req_seen_ff;
   always @(posedge pclk or negedge presetn) begin
      if (!presetn)
         req_seen_ff <= 1'b0;
      else if (havereset && debug_req)
         req_seen_ff <= 1'b1;
   end

   one_state_a: assert property ($onehot({havereset, running, halted}))
      else $error("state flags not exactly one high");
   hold_unavail_a: assert property (havereset && !fetch_enable && !$past(fetch_enable)
      && !$past(fetch_enable, 2) |=> havereset) else $error("left unavailable without permit");
   permit_leave_a: assert property (fetch_enable [*3] ##0 havereset |=> !havereset)
      else $error("reset-seen flag not cleared after permit");
   direct_halt_a: assert property ($fell(havereset) && req_seen_ff |-> halted)
      else $error("early halt request passed through running");
   halt_entry_a: assert property (running && debug_req |-> kill_decode ##1
      halted && redirect_valid && redirect_addr == $past(debugger_entry_vector))
      else $error("halt request entry wrong");
   csr_guard_a: assert property (psel && penable && !halted && paddr < 8'h10
      |-> illegal_insn && pslverr) else $error("debug csr reachable outside debug mode");
   run_trap_a: assert property (running && ebreak_exec && !debug_req |=>
      (trap_valid && running && trap_mepc == $past(decode_pc)) || (halted && !trap_valid))
      else $error("ebreak outcome wrong while running");
   dbg_ebreak_a: assert property (halted && ebreak_exec |=> halted && !trap_valid
      && redirect_valid && redirect_addr == $past(debugger_entry_vector))
      else $error("ebreak in debug mode wrong");
   fault_vec_a: assert property (halted && exc_raise && !ebreak_exec |=> redirect_valid
      && redirect_addr == $past(debugger_fault_vector)) else $error("fault vector not used");

   direct_halt_c: cover property ($fell(havereset) && halted);
   dbg_ebreak_c: cover property (halted && ebreak_exec);
   trap_c: cover property (trap_valid);
endmodule
`default_nettype wire

// *** test/dm_model.sv ***
// far-side debug module model: halt request and vectors
`timescale 1ns/1ps
`default_nettype none

module dm_model #(
   parameter [31:0] ENTRY_VEC = 32'h0000_0800,
   parameter [31:0] FAULT_VEC = 32'h0000_0808
) (
   // clock and reset
   input wire pclk,
   input wire presetn,
   // bench control and core status
   input wire halt_want,
   input wire halted,
   // request and vectors to the core
   output logic debug_req,
   output wire [31:0] debugger_entry_vector,
   output wire [31:0] debugger_fault_vector
);
   // word aligned vectors, held steady
   assign debugger_entry_vector = ENTRY_VEC;
   assign debugger_fault_vector = FAULT_VEC;
   // registered request, raised even before the permit, held until halted shows
   always @(posedge pclk or negedge presetn) begin
      if (!presetn)
         debug_req <= 1'b0;
      else
         debug_req <= halt_want && !halted;
   end
endmodule
`default_nettype wire

// *** test/core_debug_state_control_bench.sv ***
// self-checking bench for the debug state control block
`timescale 1ns/1ps
`include "dbg_consts.vh"
`default_nettype none

module core_debug_state_control_bench;
   localparam [31:0] ENTRY = 32'h0000_0800;
   localparam [31:0] FAULT = 32'h0000_0808;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, decode_pc = 32'h0000_0200, next_pc = 32'h0000_0100;
   logic fetch_enable = 1'b0, halt_want = 1'b0, decode_valid = 1'b1;
   logic [4:0] evt = 5'h00; // dret, irq, retire, exc, ebreak from msb down
   wire [31:0] prdata, redirect_addr, trap_mepc, entry_vec, fault_vec;
   wire pready, pslverr, debug_req, havereset, running, halted, debug_mode;
   wire kill_decode, illegal_insn, redirect_valid, trap_valid;
   wire [4:0] trap_mcause;
   logic [31:0] rd;
   logic er;
   int bad_count = 0, check_count = 0, cyc = 0;

   always #5 pclk = ~pclk;

   core_debug_state_control i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .fetch_enable(fetch_enable), .debug_req(debug_req),
      .debugger_entry_vector(entry_vec), .debugger_fault_vector(fault_vec),
      .havereset(havereset), .running(running), .halted(halted), .debug_mode(debug_mode),
      .decode_valid(decode_valid), .decode_pc(decode_pc), .next_pc(next_pc),
      .ebreak_exec(evt[0]), .exc_raise(evt[1]), .retire(evt[2]), .irq_taken(evt[3]),
      .dret_exec(evt[4]), .kill_decode(kill_decode), .illegal_insn(illegal_insn),
      .redirect_valid(redirect_valid), .redirect_addr(redirect_addr),
      .trap_valid(trap_valid), .trap_mepc(trap_mepc), .trap_mcause(trap_mcause));

   dm_model #(.ENTRY_VEC(ENTRY), .FAULT_VEC(FAULT)) i_dm (.pclk(pclk), .presetn(presetn),
      .halt_want(halt_want), .halted(halted), .debug_req(debug_req),
      .debugger_entry_vector(entry_vec), .debugger_fault_vector(fault_vec));

   // hang guard: the whole run needs well under a thousand cycles
   always @(posedge pclk) begin
      cyc <= cyc + 1;
      if (cyc == 5000) begin
         bad_count = bad_count + 1;
         report_and_stop();
      end
   end

   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         bad_count++;
         $display("[ERR] %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   // one bus transfer; request held until pready is sampled high
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      // no timeout of its own; only the hang guard ends a wait on a stuck pready
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      chk(nm, rd, exp);
   endtask

   // one-cycle pipeline event; returns just after the edge that answers it
   task automatic ev(input logic [4:0] m);
      @(posedge pclk);
      evt <= m;
      @(posedge pclk);
      evt <= 5'h00;
      #1;
   endtask

   task automatic wait_halt();
      int k;
      k = 0;
      while (halted !== 1'b1 && k < 20) begin
         @(posedge pclk);
         #1;
         k++;
      end
   endtask

   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", check_count, bad_count);
      if (bad_count == 0 && check_count > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask

   initial begin
      repeat (16) @(posedge pclk);
      chk("in reset", {havereset, running, halted}, 3'b100);
      presetn <= 1'b1;
      repeat (10) @(posedge pclk);
      #1;
      chk("no permit", havereset, 1'b1);
      // request before the permit must skip running
      @(posedge pclk);
      halt_want <= 1'b1;
      @(posedge pclk);
      fetch_enable <= 1'b1;
      wait_halt();
      chk("direct halt", {havereset, running, halted}, 3'b001);
      @(posedge pclk);
      halt_want <= 1'b0;
      $display("test startup done");
      rchk("dpc", `ADDR_DPC, 32'h0000_0100);
      rchk("dcsr", `ADDR_DCSR, 32'h4000_00c3);
      apb(1'b1, `ADDR_DCSR, 32'h0000_8000);
      rchk("dcsr", `ADDR_DCSR, 32'h4000_80c3);
      apb(1'b1, `ADDR_DSCRATCH1, 32'ha5a5_5a5a);
      rchk("scratch", `ADDR_DSCRATCH1, 32'ha5a5_5a5a);
      apb(1'b1, `ADDR_TDATA1, 32'h0);
      rchk("tdata1", `ADDR_TDATA1, 32'h2800_0000);
      apb(1'b1, `ADDR_TDATA2, 32'h0000_0400);
      rchk("state", `ADDR_DSTATE, 32'h4);
      rchk("unmapped", 8'h24, 32'h0);
      chk("unmapped err", er, 1'b1);
      ev(5'h01);
      chk("dbg ebreak", {halted, redirect_valid, trap_valid}, 3'b110);
      chk("entry vec", redirect_addr, ENTRY);
      rchk("dcsr kept", `ADDR_DCSR, 32'h4000_80c3);
      ev(5'h02);
      chk("fault vec", redirect_addr, FAULT);
      $display("test debug registers done");
      // advance past the halted instruction, then resume
      apb(1'b1, `ADDR_DPC, 32'h0000_0104);
      ev(5'h10);
      chk("resume", running, 1'b1);
      chk("mode off", debug_mode, 1'b0);
      chk("resume pc", redirect_addr, 32'h0000_0104);
      rchk("dcsr outside", `ADDR_DCSR, 32'h0);
      chk("illegal", er, 1'b1);
      apb(1'b1, `ADDR_TDATA2, 32'hdead_beef);
      rchk("tdata2 kept", `ADDR_TDATA2, 32'h0000_0400);
      ev(5'h01);
      chk("ebreak entry", {halted, trap_valid}, 2'b10);
      rchk("ebreak dpc", `ADDR_DPC, 32'h0000_0200);
      rchk("ebreak cause", `ADDR_DCSR, 32'h4000_8043);
      apb(1'b1, `ADDR_DCSR, 32'h0);
      apb(1'b1, `ADDR_DPC, 32'h0000_0204);
      ev(5'h10);
      ev(5'h01);
      chk("trap", {running, trap_valid}, 2'b11);
      chk("mepc", trap_mepc, 32'h0000_0200);
      chk("mcause", trap_mcause, `EXC_BREAKPOINT);
      $display("test ebreak done");
      @(posedge pclk);
      halt_want <= 1'b1;
      wait_halt();
      chk("halt req", halted, 1'b1);
      @(posedge pclk);
      halt_want <= 1'b0;
      rchk("req dpc", `ADDR_DPC, 32'h0000_0200);
      rchk("req cause", `ADDR_DCSR, 32'h4000_00c3);
      // single step interrupted: handler's first instruction retires first
      apb(1'b1, `ADDR_DCSR, 32'h0000_0004);
      ev(5'h10);
      ev(5'h08);
      chk("irq no halt", running, 1'b1);
      ev(5'h04);
      chk("step halt", halted, 1'b1);
      rchk("step cause", `ADDR_DCSR, 32'h4000_0107);
      rchk("step dpc", `ADDR_DPC, 32'h0000_0100);
      $display("test halt and step done");
      // execute trigger on the pc held in tdata2
      apb(1'b1, `ADDR_TDATA1, 32'h0000_0044);
      rchk("tdata1 set", `ADDR_TDATA1, 32'h2800_0044);
      @(posedge pclk);
      decode_pc <= 32'h0000_0400;
      ev(5'h10);
      wait_halt();
      chk("trig halt", {halted, debug_mode}, 2'b11);
      rchk("trig cause", `ADDR_DCSR, 32'h4000_0087);
      rchk("trig dpc", `ADDR_DPC, 32'h0000_0400);
      $display("test trigger done");
      report_and_stop();
   end
endmodule

bind core_debug_state_control dbg_state_props i_props (.pclk(pclk), .presetn(presetn),
   .psel(psel), .penable(penable), .paddr(paddr), .pslverr(pslverr),
   .fetch_enable(fetch_enable), .debug_req(debug_req),
   .debugger_entry_vector(debugger_entry_vector), .debugger_fault_vector(debugger_fault_vector),
   .havereset(havereset), .running(running), .halted(halted), .decode_pc(decode_pc),
   .ebreak_exec(ebreak_exec), .exc_raise(exc_raise), .kill_decode(kill_decode),
   .illegal_insn(illegal_insn), .redirect_valid(redirect_valid),
   .redirect_addr(redirect_addr), .trap_valid(trap_valid), .trap_mepc(trap_mepc));
`default_nettype wire
